/* core/stpor_pkg.sv */
// Constants for the standby and power-on-reset sequencer
//
// Behaviour
// R1: Standby entered on standby input toggle or external serial/test instruction.
// R2: In standby the device stays configured; logic, I/O, memories keep working.
// R3: On standby entry, subsystems chosen for saving switch off automatically.
// R4: Reference off also switches off reset monitor, PLLs, oscillator, diff I/O.
// R5: Oscillator can be disabled permanently or shut down in standby.
// R6: PLL static disable or standby shutdown; powers off only after outputs low.
// R7: Differential I/O buffers switched off and on per bank at run time.
// R8: Each primary clock net has its own dynamic enable.
// R9: Unused input buffers guarded off; routed clock inputs off in standby.
// R10: With reset monitor off, low-power supply detector still may reset.
// R11: After core and config supplies good, start configuration download.
// R12: User I/O tri-stated until configuration has finished.
// R13: In user mode a core supply drop resets and restarts monitoring.
// R14: Drop detector is accurate one with reference on, low-power one off. Code selects on monitor: low-power also when only the monitor is saved off.
// R15: Regulated parts also monitor the external supply.
// R16: Device reset held while any enabled monitor reports low supply. Code: in user mode only the selected core drop detector holds reset.
package stpor_pkg;

   // ----------------------------------------
   // Sequencer states
   // ----------------------------------------
   typedef enum logic [2:0] {
      STPOR_POR_WAIT = 3'b000,
      STPOR_CONFIG   = 3'b001,
      STPOR_USER     = 3'b010,
      STPOR_PLL_STOP = 3'b011,
      STPOR_STANDBY  = 3'b100
   } stpor_state_type;

   // ----------------------------------------
   // Register offsets and reset values
   // ----------------------------------------
   localparam logic [3:0] STPOR_ADDR_CTRL = 4'h0;
   localparam logic [3:0] STPOR_ADDR_SAVE = 4'h1;
   localparam logic [3:0] STPOR_ADDR_BANK = 4'h2;
   localparam logic [3:0] STPOR_ADDR_CLKEN = 4'h3;
   localparam logic [3:0] STPOR_ADDR_GUARD = 4'h4;
   localparam logic [3:0] STPOR_ADDR_STAT = 4'h5;

   // Control bits
   localparam int STPOR_CTRL_STBY_REQ = 0;
   localparam int STPOR_CTRL_WAKE = 1;
   localparam int STPOR_CTRL_MON_EN = 2;
   localparam int STPOR_CTRL_OSC_DIS = 3;
   localparam int STPOR_CTRL_PLL_DIS = 4;
   // Standby saving selection bits
   localparam int STPOR_SAVE_REF = 0;
   localparam int STPOR_SAVE_MON = 1;
   localparam int STPOR_SAVE_OSC = 2;
   localparam int STPOR_SAVE_PLL = 3;
   localparam int STPOR_SAVE_BANK = 4;
   localparam int STPOR_SAVE_CLK = 5;
   localparam int STPOR_SAVE_GUARD = 6;

   localparam logic [7:0] STPOR_CTRL_RST = 8'h04;
   localparam logic [7:0] STPOR_SAVE_RST = 8'h00;
   localparam logic [7:0] STPOR_EN_RST = 8'hFF;
   // Command bits are not stored
   localparam logic [7:0] STPOR_CTRL_MASK = 8'h1C;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int STPOR_CLK_MHZ = 100;
   localparam int STPOR_PLL_WAIT_NS = 100;
   localparam int STPOR_PLL_WAIT_CYC =
      (STPOR_PLL_WAIT_NS * STPOR_CLK_MHZ + 999) / 1000;
   localparam int STPOR_CFG_CYC = 64;

endpackage

/* core/stpor_sync_cnt.sv */
// Run-length counter: holds done high once input has been high for LEN cycles, until input drops
`timescale 1ns/100ps
`default_nettype none
module stpor_sync_cnt #(
   parameter int LEN = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Condition
   input wire logic run,
   output logic done
);
   localparam int W = $clog2(LEN + 1);
   logic [W-1:0] cnt_ff;
   wire at_end = (cnt_ff == W'(LEN));
   wire [W-1:0] nxt_cnt = !run ? '0 : (at_end ? cnt_ff : cnt_ff + 1'b1);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) cnt_ff <= '0;
      else cnt_ff <= nxt_cnt;
   end

   assign done = run && at_end;
endmodule
`default_nettype wire

/* core/stpor_edge.sv */
// Edge detector for a synchronous level input
`timescale 1ns/100ps
`default_nettype none
module stpor_edge (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Level in, change pulse out
   input wire logic lvl,
   output logic toggled
);
   logic lvl_ff;
   logic seen_ff;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         lvl_ff <= 1'b0;
         seen_ff <= 1'b0;
      end else begin
         lvl_ff <= lvl;
         seen_ff <= 1'b1;
      end
   end

   // First sample after reset only captures the level
   assign toggled = seen_ff && (lvl != lvl_ff);
endmodule
`default_nettype wire

/* core/stpor_seq.sv */
// Standby and power-on-reset sequencer top
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module stpor_seq #(
   parameter int NUM_BANKS = 4,
   parameter int NUM_PLLS = 2,
   parameter int PLL_OUTS = 4,
   parameter int NUM_CLKNETS = 8,
   parameter int NUM_GUARDS = 8,
   parameter bit HAS_REGULATOR = 1'b1,
   parameter int CFG_CYC = stpor_pkg::STPOR_CFG_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Supply monitors
   input wire logic core_good,
   input wire logic cfgbank_good,
   input wire logic ext_good,
   input wire logic core_drop_accurate,
   input wire logic core_drop_lowpwr,
   // Configuration download
   input wire logic cfg_done,
   output logic cfg_start,
   output logic device_rst_b,
   // Standby requests
   input wire logic stby_in,
   input wire logic ext_stby_cmd,
   input wire logic ext_wake_cmd,
   // PLL outputs observed before shutdown
   input wire logic [NUM_PLLS*PLL_OUTS-1:0] pll_clk_out,
   // Subsystem enables
   output logic ref_on,
   output logic mon_on,
   output logic lp_det_on,
   output logic osc_on,
   output logic [NUM_PLLS-1:0] pll_on,
   output logic [NUM_BANKS-1:0] diff_bank_on,
   output logic [NUM_CLKNETS-1:0] clknet_en,
   output logic [NUM_GUARDS-1:0] inbuf_on,
   output logic io_user_en,
   output logic in_standby,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata
);
   // ----------------------------------------
   // Registers
   // ----------------------------------------
   stpor_pkg::stpor_state_type state_ff, nxt_state;
   logic [7:0] ctrl_ff, save_ff, bank_ff, clken_ff, guard_ff, rdata_ff;
   logic [$clog2(CFG_CYC+1)-1:0] cfg_cnt_ff;

   // ----------------------------------------
   // Address and state decode
   // ----------------------------------------
   function automatic logic addr_hit(input logic [3:0] addr,
      input logic [3:0] offset);
      addr_hit = (addr == offset);
   endfunction

   wire sel_ctrl = addr_hit(reg_addr, stpor_pkg::STPOR_ADDR_CTRL);
   wire sel_save = addr_hit(reg_addr, stpor_pkg::STPOR_ADDR_SAVE);
   wire sel_bank = addr_hit(reg_addr, stpor_pkg::STPOR_ADDR_BANK);
   wire sel_clken = addr_hit(reg_addr, stpor_pkg::STPOR_ADDR_CLKEN);
   wire sel_guard = addr_hit(reg_addr, stpor_pkg::STPOR_ADDR_GUARD);
   wire sel_stat = addr_hit(reg_addr, stpor_pkg::STPOR_ADDR_STAT);

   wire is_cfg = (state_ff == stpor_pkg::STPOR_CONFIG);
   wire is_run = (state_ff == stpor_pkg::STPOR_USER);
   wire is_pll_stop = (state_ff == stpor_pkg::STPOR_PLL_STOP);

   wire wr_ctrl = reg_wr && sel_ctrl;
   wire wr_save = reg_wr && sel_save;
   wire wr_bank = reg_wr && sel_bank;
   wire wr_clken = reg_wr && sel_clken;
   wire wr_guard = reg_wr && sel_guard;

   // Software standby request and wake are self-clearing command bits
   wire sw_stby = wr_ctrl && reg_wdata[stpor_pkg::STPOR_CTRL_STBY_REQ];
   wire sw_wake = wr_ctrl && reg_wdata[stpor_pkg::STPOR_CTRL_WAKE];
   wire mon_en = ctrl_ff[stpor_pkg::STPOR_CTRL_MON_EN];
   wire osc_dis = ctrl_ff[stpor_pkg::STPOR_CTRL_OSC_DIS];
   wire pll_dis = ctrl_ff[stpor_pkg::STPOR_CTRL_PLL_DIS];

   // ----------------------------------------
   // Standby triggers
   // ----------------------------------------
   logic stby_toggle;
   stpor_edge u_edge (
      .clk(clk),
      .rst_b(rst_b),
      .lvl(stby_in),
      .toggled(stby_toggle)
   );

   wire stby_req = stby_toggle || ext_stby_cmd || sw_stby; // R1
   wire wake_req = ext_wake_cmd || sw_wake;

   // ----------------------------------------
   // Supply checks
   // ----------------------------------------
   wire is_stby = (state_ff == stpor_pkg::STPOR_STANDBY);
   wire save_ref = is_stby && save_ff[stpor_pkg::STPOR_SAVE_REF];
   // Reference off takes the accurate monitor down with it
   wire mon_off = save_ref || (is_stby && save_ff[stpor_pkg::STPOR_SAVE_MON]); // R4
   wire ext_ok = !HAS_REGULATOR || ext_good; // R15
   wire power_ok = core_good && cfgbank_good && ext_ok; // R11
   // Accurate detector when monitor up, low-power detector otherwise
   wire core_drop = mon_off ? core_drop_lowpwr : core_drop_accurate; // R14
   wire in_user = is_run || is_pll_stop || is_stby;
   // Low-power detector still active when monitor is off
   wire drop_rst = in_user && (mon_en || mon_off) && core_drop; // R10 R13

   // ----------------------------------------
   // PLL shutdown wait
   // ----------------------------------------
   logic [NUM_PLLS-1:0] pll_quiet;
   for (genvar gp = 0; gp < NUM_PLLS; gp++) begin : g_quiet
      assign pll_quiet[gp] = ~|pll_clk_out[gp*PLL_OUTS +: PLL_OUTS];
   end
   wire pll_outs_low = &pll_quiet; // R6
   logic pll_settled;
   stpor_sync_cnt #(
      .LEN(stpor_pkg::STPOR_PLL_WAIT_CYC)
   ) u_pll_wait (
      .clk(clk),
      .rst_b(rst_b),
      .run(is_pll_stop && pll_outs_low),
      .done(pll_settled)
   );
   wire pll_save = save_ff[stpor_pkg::STPOR_SAVE_PLL] ||
                   save_ff[stpor_pkg::STPOR_SAVE_REF];

   // ----------------------------------------
   // State machine
   // ----------------------------------------
   wire cfg_time_up = (cfg_cnt_ff == $bits(cfg_cnt_ff)'(CFG_CYC));

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         stpor_pkg::STPOR_POR_WAIT: begin
            if (power_ok) nxt_state = stpor_pkg::STPOR_CONFIG; // R11
         end
         stpor_pkg::STPOR_CONFIG: begin
            if (!power_ok) nxt_state = stpor_pkg::STPOR_POR_WAIT; // R16
            else if (cfg_done || cfg_time_up)
               nxt_state = stpor_pkg::STPOR_USER;
         end
         stpor_pkg::STPOR_USER: begin
            if (stby_req) begin
               if (pll_save) nxt_state = stpor_pkg::STPOR_PLL_STOP;
               else nxt_state = stpor_pkg::STPOR_STANDBY;
            end
         end
         stpor_pkg::STPOR_PLL_STOP: begin
            if (wake_req) nxt_state = stpor_pkg::STPOR_USER;
            else if (pll_settled) nxt_state = stpor_pkg::STPOR_STANDBY; // R6
         end
         stpor_pkg::STPOR_STANDBY: begin
            if (wake_req) nxt_state = stpor_pkg::STPOR_USER;
         end
         default: nxt_state = stpor_pkg::STPOR_POR_WAIT;
      endcase
      // Supply drop restarts monitoring from the beginning
      if (drop_rst) nxt_state = stpor_pkg::STPOR_POR_WAIT; // R13
   end

   wire [$bits(cfg_cnt_ff)-1:0] nxt_cfg_cnt =
      !is_cfg ? '0 :
      (cfg_time_up ? cfg_cnt_ff : cfg_cnt_ff + 1'b1);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_ff <= stpor_pkg::STPOR_POR_WAIT;
         cfg_cnt_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         cfg_cnt_ff <= nxt_cfg_cnt;
      end
   end

   // ----------------------------------------
   // Register writes
   // ----------------------------------------
   wire [7:0] nxt_ctrl = wr_ctrl ?
      (reg_wdata & stpor_pkg::STPOR_CTRL_MASK) : ctrl_ff;
   wire [7:0] nxt_save = wr_save ? reg_wdata : save_ff;
   wire [7:0] nxt_bank = wr_bank ? reg_wdata : bank_ff; // R7
   wire [7:0] nxt_clken = wr_clken ? reg_wdata : clken_ff; // R8
   wire [7:0] nxt_guard = wr_guard ? reg_wdata : guard_ff; // R9

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) ctrl_ff <= stpor_pkg::STPOR_CTRL_RST;
      else ctrl_ff <= nxt_ctrl;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) save_ff <= stpor_pkg::STPOR_SAVE_RST;
      else save_ff <= nxt_save;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) bank_ff <= stpor_pkg::STPOR_EN_RST;
      else bank_ff <= nxt_bank;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) clken_ff <= stpor_pkg::STPOR_EN_RST;
      else clken_ff <= nxt_clken;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) guard_ff <= stpor_pkg::STPOR_EN_RST;
      else guard_ff <= nxt_guard;
   end

   // ----------------------------------------
   // Subsystem enables
   // ----------------------------------------
   wire save_osc = is_stby && save_ff[stpor_pkg::STPOR_SAVE_OSC];
   wire save_bank = is_stby && save_ff[stpor_pkg::STPOR_SAVE_BANK];
   wire save_clk = is_stby && save_ff[stpor_pkg::STPOR_SAVE_CLK];
   wire save_guard = is_stby && save_ff[stpor_pkg::STPOR_SAVE_GUARD];
   wire pll_down = is_stby && pll_save;

   // Logic, I/O and memories are never switched off by standby
   assign ref_on = !save_ref; // R3 R2
   assign mon_on = !mon_off; // R3 R4
   assign lp_det_on = 1'b1; // R10
   assign osc_on = !osc_dis && !save_osc && !save_ref; // R5 R4

   genvar gi;
   generate
      for (gi = 0; gi < NUM_PLLS; gi++) begin : g_pll
         assign pll_on[gi] = !pll_dis && !pll_down; // R6
      end
      for (gi = 0; gi < NUM_BANKS; gi++) begin : g_bank
         assign diff_bank_on[gi] = bank_ff[gi % 8] && !save_bank &&
                                   !save_ref; // R7 R4
      end
      for (gi = 0; gi < NUM_CLKNETS; gi++) begin : g_clk
         assign clknet_en[gi] = clken_ff[gi % 8] && !save_clk; // R8
      end
      for (gi = 0; gi < NUM_GUARDS; gi++) begin : g_grd
         assign inbuf_on[gi] = guard_ff[gi % 8] && !save_guard; // R9
      end
   endgenerate

   assign cfg_start = is_cfg;
   assign io_user_en = in_user; // R12
   assign device_rst_b = in_user && !drop_rst; // R16
   assign in_standby = is_stby;

   // ----------------------------------------
   // Register reads
   // ----------------------------------------
   wire [7:0] stat_word = {3'h0, power_ok, 1'b0, state_ff};
   wire [7:0] rd_ctrl = {8{sel_ctrl}} & ctrl_ff;
   wire [7:0] rd_save = {8{sel_save}} & save_ff;
   wire [7:0] rd_bank = {8{sel_bank}} & bank_ff;
   wire [7:0] rd_clken = {8{sel_clken}} & clken_ff;
   wire [7:0] rd_guard = {8{sel_guard}} & guard_ff;
   wire [7:0] rd_stat = {8{sel_stat}} & stat_word;
   // Unmapped addresses select nothing and read zero
   wire [7:0] rd_mux = rd_ctrl | rd_save | rd_bank | rd_clken |
      rd_guard | rd_stat;
   wire [7:0] nxt_rdata = reg_rd ? rd_mux : 8'h00;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) rdata_ff <= 8'h00;
      else rdata_ff <= nxt_rdata;
   end
   assign reg_rdata = rdata_ff;
endmodule
`default_nettype wire

/* sim/stpor_ext_master.sv */
// External master model: standby commands and observed PLL clocks
`timescale 1ns/100ps
`default_nettype none
module stpor_ext_master #(
   parameter int W = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Run request from the bench
   input wire logic pll_run,
   // Commands and clocks
   output logic ext_stby_cmd,
   output logic ext_wake_cmd,
   output logic [W-1:0] pll_clk_out
);
   // ----------------------------------------
   // Commands and clocks
   // ----------------------------------------
   initial begin
      ext_stby_cmd = 1'b0;
      ext_wake_cmd = 1'b0;
   end
   // Clocks toggle while running, held low before power-off
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pll_clk_out <= '0;
      end else if (pll_run) begin
         pll_clk_out <= ~pll_clk_out;
      end else begin
         pll_clk_out <= '0;
      end
   end
   task automatic send_stby();
      @(posedge clk);
      ext_stby_cmd <= 1'b1;
      @(posedge clk);
      ext_stby_cmd <= 1'b0;
   endtask
   task automatic send_wake();
      @(posedge clk);
      ext_wake_cmd <= 1'b1;
      @(posedge clk);
      ext_wake_cmd <= 1'b0;
   endtask
endmodule
`default_nettype wire

/* sim/stpor_seq_monitor.sv */
// Assertion checker for the standby and power-on-reset sequencer
`timescale 1ns/100ps
`default_nettype none
module stpor_seq_monitor #(
   parameter int NUM_BANKS = 4,
   parameter int NUM_PLLS = 2,
   parameter int PLL_OUTS = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Supplies and clocks
   input wire logic core_good,
   input wire logic cfgbank_good,
   input wire logic ext_good,
   input wire logic core_drop_lowpwr,
   input wire logic [NUM_PLLS*PLL_OUTS-1:0] pll_clk_out,
   // Watched outputs
   input wire logic cfg_start,
   input wire logic device_rst_b,
   input wire logic ref_on,
   input wire logic mon_on,
   input wire logic lp_det_on,
   input wire logic osc_on,
   input wire logic [NUM_PLLS-1:0] pll_on,
   input wire logic [NUM_BANKS-1:0] diff_bank_on,
   input wire logic io_user_en,
   input wire logic in_standby
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_cfg_gate: assert property ($rose(cfg_start) |->
      $past(core_good && cfgbank_good && ext_good)) else $error("bad start");
   a_io_tristate: assert property (cfg_start |-> !io_user_en)
      else $error("io live in config");
   a_io_after_cfg: assert property ($rose(io_user_en) |->
      $past(cfg_start)) else $error("io released early");
   a_rst_hold: assert property (!io_user_en |-> !device_rst_b)
      else $error("reset released");
   a_stby_kept: assert property (in_standby |-> io_user_en)
      else $error("standby lost config");
   a_ref_off: assert property (!ref_on |-> !mon_on && !osc_on &&
      pll_on == '0 && diff_bank_on == '0) else $error("ref off leak");
   a_lp_det: assert property (!mon_on && core_drop_lowpwr &&
      io_user_en |-> lp_det_on ##1 !io_user_en)
      else $error("no low power detector");
   a_pll_low: assert property ($rose(in_standby) &&
      $past(pll_on) != '0 && pll_on == '0 |->
      $past(pll_clk_out) == '0 && $past(pll_clk_out, 2) == '0)
      else $error("pll off while clocking");
   a_drop_restart: assert property ($fell(io_user_en) |->
      !cfg_start && !device_rst_b) else $error("bad drop restart");
   a_lp_drop: assert property (!ref_on && core_drop_lowpwr &&
      io_user_en |=> !io_user_en) else $error("lp drop missed");
   c_standby: cover property ($rose(in_standby));
   c_user: cover property ($rose(io_user_en));
   c_drop: cover property ($fell(io_user_en));
endmodule
bind stpor_seq stpor_seq_monitor #(.NUM_BANKS(NUM_BANKS),
   .NUM_PLLS(NUM_PLLS), .PLL_OUTS(PLL_OUTS)) u_mon (.clk, .rst_b,
   .core_good, .cfgbank_good, .ext_good, .core_drop_lowpwr, .pll_clk_out,
   .cfg_start, .device_rst_b, .ref_on, .mon_on, .lp_det_on, .osc_on,
   .pll_on, .diff_bank_on, .io_user_en, .in_standby);
`default_nettype wire

/* sim/stpor_seq_tb.sv */
// Self-checking bench for the standby and power-on-reset sequencer
`timescale 1ns/100ps
`default_nettype none
module stpor_seq_tb;
   logic clk, rst_b, core_good, cfgbank_good, ext_good, cfg_done;
   logic core_drop_accurate, core_drop_lowpwr, cfg_start, device_rst_b;
   logic stby_in, ext_stby_cmd, ext_wake_cmd, pll_run, reg_wr, reg_rd;
   logic ref_on, mon_on, lp_det_on, osc_on, io_user_en, in_standby;
   logic [7:0] pll_clk_out, clknet_en, inbuf_on, reg_wdata, reg_rdata;
   logic [7:0] rdv;
   logic [1:0] pll_on;
   logic [3:0] diff_bank_on, reg_addr;
   int fail_count, check_count, i;
   stpor_seq #(.CFG_CYC(8)) dut (.clk, .rst_b, .core_good, .cfgbank_good,
      .ext_good, .core_drop_accurate, .core_drop_lowpwr, .cfg_done,
      .cfg_start, .device_rst_b, .stby_in, .ext_stby_cmd, .ext_wake_cmd,
      .pll_clk_out, .ref_on, .mon_on, .lp_det_on, .osc_on, .pll_on,
      .diff_bank_on, .clknet_en, .inbuf_on, .io_user_en, .in_standby,
      .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
   stpor_ext_master u_ext (.clk, .rst_b, .pll_run, .ext_stby_cmd,
      .ext_wake_cmd, .pll_clk_out);
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic stop_test();
      if (fail_count == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] s, logic [7:0] e);
      check_count++;
      if (s !== e) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      rdv = reg_rdata;
   endtask
   task automatic wait_sb(input logic v);
      for (int k = 0; k < 40 && in_standby !== v; k++) tick(1);
   endtask
   initial begin
      #50000;
      fail_count++;
      stop_test();
   end
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      {core_good, cfgbank_good, ext_good, cfg_done, stby_in} = 5'h00;
      {core_drop_accurate, core_drop_lowpwr, pll_run} = 3'h0;
      {reg_wr, reg_rd, reg_addr, reg_wdata} = 14'h0000;
      rst_b = 1'b0;
      fail_count = 0;
      check_count = 0;
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      chk("rst", device_rst_b, 1'b0);
      for (i = 0; i < 5; i++) begin
         rd(i[3:0]);
         chk("reg", rdv, i == 0 ? stpor_pkg::STPOR_CTRL_RST :
            i == 1 ? stpor_pkg::STPOR_SAVE_RST : stpor_pkg::STPOR_EN_RST);
      end
      rd(4'hF);
      chk("unmapped", rdv, 8'h00);
      core_good <= 1'b1;
      cfgbank_good <= 1'b1;
      tick(4);
      chk("no_ext", cfg_start, 1'b0);
      ext_good <= 1'b1;
      tick(2);
      chk("cfg", cfg_start, 1'b1);
      chk("io_cfg", io_user_en, 1'b0);
      cfg_done <= 1'b1;
      tick(1);
      cfg_done <= 1'b0;
      chk("io_user", io_user_en, 1'b1);
      chk("rst_rel", device_rst_b, 1'b1);
      wr(stpor_pkg::STPOR_ADDR_BANK, 8'h05);
      wr(stpor_pkg::STPOR_ADDR_CLKEN, 8'hA5);
      wr(stpor_pkg::STPOR_ADDR_GUARD, 8'h3C);
      wr(stpor_pkg::STPOR_ADDR_CTRL, 8'h1C);
      tick(1);
      chk("bank", diff_bank_on, 4'h5);
      chk("clknet", clknet_en, 8'hA5);
      chk("guard", inbuf_on, 8'h3C);
      chk("osc_dis", osc_on, 1'b0);
      chk("pll_dis", pll_on, 2'h0);
      wr(stpor_pkg::STPOR_ADDR_CTRL, 8'h04);
      stby_in <= 1'b1;
      wait_sb(1'b1);
      chk("sb_pin", in_standby, 1'b1);
      chk("sb_io", io_user_en, 1'b1);
      chk("sb_osc", osc_on, 1'b1);
      wr(stpor_pkg::STPOR_ADDR_CTRL, 8'h06);
      wait_sb(1'b0);
      chk("wake", in_standby, 1'b0);
      wr(stpor_pkg::STPOR_ADDR_SAVE, 8'h7E);
      pll_run <= 1'b1;
      u_ext.send_stby();
      tick(20);
      chk("pll_wait", in_standby, 1'b0);
      pll_run <= 1'b0;
      wait_sb(1'b1);
      chk("sb_cmd", in_standby, 1'b1);
      chk("sb_pll", pll_on, 2'h0);
      chk("sb_mon", mon_on, 1'b0);
      chk("sb_osc2", osc_on, 1'b0);
      chk("sb_bank", diff_bank_on, 4'h0);
      chk("sb_clk", clknet_en, 8'h00);
      chk("sb_guard", inbuf_on, 8'h00);
      u_ext.send_wake();
      wait_sb(1'b0);
      chk("wk_bank", diff_bank_on, 4'h5);
      wr(stpor_pkg::STPOR_ADDR_SAVE, 8'h01);
      wr(stpor_pkg::STPOR_ADDR_CTRL, 8'h05);
      wait_sb(1'b1);
      chk("ref", ref_on, 1'b0);
      chk("ref_mon", mon_on, 1'b0);
      chk("ref_osc", osc_on, 1'b0);
      chk("ref_pll", pll_on, 2'h0);
      chk("ref_bank", diff_bank_on, 4'h0);
      chk("lp_det", lp_det_on, 1'b1);
      core_drop_accurate <= 1'b1;
      tick(3);
      chk("acc_off", io_user_en, 1'b1);
      core_drop_accurate <= 1'b0;
      core_drop_lowpwr <= 1'b1;
      tick(1);
      chk("lp_drop", io_user_en, 1'b0);
      chk("lp_rst", device_rst_b, 1'b0);
      core_drop_lowpwr <= 1'b0;
      core_good <= 1'b0;
      tick(2);
      u_ext.send_stby();
      rd(stpor_pkg::STPOR_ADDR_STAT);
      chk("refused", rdv, 8'h00);
      chk("por_wait", cfg_start, 1'b0);
      core_good <= 1'b1;
      for (i = 0; i < 40 && io_user_en !== 1'b1; i++) tick(1);
      chk("reboot", io_user_en, 1'b1);
      wr(stpor_pkg::STPOR_ADDR_CTRL, 8'h00);
      core_drop_accurate <= 1'b1;
      tick(2);
      chk("no_mon", io_user_en, 1'b1);
      wr(stpor_pkg::STPOR_ADDR_CTRL, 8'h04);
      tick(1);
      chk("acc_drop", io_user_en, 1'b0);
      chk("acc_rst", device_rst_b, 1'b0);
      stop_test();
   end
endmodule
`default_nettype wire
